// ==== common/dso_map.svh ====
`ifndef DSO_MAP_SVH
`define DSO_MAP_SVH
// ****************************************
// Register offsets
// ****************************************
`define DSO_OFS_FUNC_A     8'h00
`define DSO_OFS_FUNC_B     8'h04
`define DSO_OFS_SENSE      8'h08
`define DSO_OFS_ZS_THRESH  8'h0c
`define DSO_OFS_CONTROL    8'h10
`define DSO_OFS_STATUS     8'h14
`define DSO_OFS_IRQ_STATUS 8'h18
`define DSO_OFS_IRQ_MASK   8'h1c
// ****************************************
// Field positions
// ****************************************
`define DSO_CTL_SENSOR_BIT 0
`define DSO_CTL_TRIPRST_BIT 1
`define DSO_SENSE_RELAY_LSB 10
`define DSO_FN_RELAY_LSB   8
// ****************************************
// Flag indices and function codes
// ****************************************
`define DSO_FL_ZS          0
`define DSO_FL_READY       1
`define DSO_FL_FWD         2
`define DSO_FL_REV         3
`define DSO_FL_ALARM       4
`define DSO_FN_ALARM       8'h05
`define DSO_FN_ZS          8'h15
`define DSO_FN_READY       8'h32
`define DSO_FN_FWD         8'h33
`define DSO_FN_REV         8'h34
`define DSO_SENSE_NO       2'h0
`define DSO_SENSE_NC       2'h1
// ****************************************
// Reset values and limits
// ****************************************
`define DSO_RST_FUNC_A     32'h0000_0000
`define DSO_RST_FUNC_B     32'h0000_0500
`define DSO_RST_SENSE      32'h0000_0400
`define DSO_RST_ZS_THRESH  16'h0000
`define DSO_ZS_THRESH_MAX  16'h270f
`define DSO_RESP_OKAY      2'h0
`define DSO_RESP_SLVERR    2'h2
`endif

// ==== common/dso_pkg.sv ====
// ****************************************
// Shared types
// ****************************************
package dso_pkg;
   // Drive run state, one-hot
   typedef enum logic [2:0] {
      DSO_ST_STOP = 3'b001,
      DSO_ST_FWD  = 3'b010,
      DSO_ST_REV  = 3'b100
   } dso_run_state_t;
   typedef logic [7:0]  dso_func_t;
   typedef logic [1:0]  dso_sense_t;
   typedef logic [4:0]  dso_flags_t;
   typedef logic [15:0] dso_freq_t;
endpackage

// ==== verilog/dso_out_cell.sv ====
`timescale 1ns/1ps
`include "dso_map.svh"
// ****************************************
// One output terminal: select, then sense
// ****************************************
module dso_out_cell (
   input  wire logic              mclk,
   input  wire logic              reset,
   input  wire dso_pkg::dso_func_t  func_sel,
   input  wire dso_pkg::dso_sense_t sense_sel,
   input  wire dso_pkg::dso_flags_t flags,
   output logic                   drive
);
   // Code to flag; unknown codes give an idle output
   function automatic logic pick(input dso_pkg::dso_func_t code,
                                 input dso_pkg::dso_flags_t fl);
      case (code)
         `DSO_FN_ZS:    pick = fl[`DSO_FL_ZS];
         `DSO_FN_READY: pick = fl[`DSO_FL_READY];
         `DSO_FN_FWD:   pick = fl[`DSO_FL_FWD];
         `DSO_FN_REV:   pick = fl[`DSO_FL_REV];
         `DSO_FN_ALARM: pick = fl[`DSO_FL_ALARM];
         default:       pick = 1'b0;
      endcase
   endfunction

   logic next_drive;

   // Selection first, inversion second
   always_comb begin
      next_drive = pick(func_sel, flags) ^ (sense_sel == `DSO_SENSE_NC);
   end

   // One register stage per terminal
   always_ff @(posedge mclk) begin
      if (reset) begin
         drive <= 1'b0;
      end else begin
         drive <= next_drive;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   property p_cell_latency;
      !$past(reset) |-> drive == $past(next_drive);
   endproperty
   a_cell_latency: assert property (p_cell_latency)
      else $error("output not one cycle after its flag");

   property p_cell_nc;
      (sense_sel == `DSO_SENSE_NC && func_sel == `DSO_FN_ZS)
         |=> drive == !$past(flags[`DSO_FL_ZS]);
   endproperty
   a_cell_nc: assert property (p_cell_nc)
      else $error("normally closed output not inverted");
endmodule

// ==== verilog/dso_status_outputs.sv ====
`timescale 1ns/1ps
`include "dso_map.svh"
module dso_status_outputs (
   input  wire logic                  mclk,
   input  wire logic                  reset,
   // AXI4-Lite slave
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [7:0]            s_axi_awaddr,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   output logic [1:0]                 s_axi_bresp,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   input  wire logic [7:0]            s_axi_araddr,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   // Drive side
   input  wire dso_pkg::dso_freq_t    output_freq,
   input  wire dso_pkg::dso_freq_t    motor_freq,
   input  wire logic                  supply_ok,
   input  wire logic                  trip_event,
   input  wire logic                  trip_reset,
   input  wire logic                  run_fwd_cmd,
   input  wire logic                  run_rev_cmd,
   output logic                       drive_active,
   // Terminals
   output logic                       transistor_output_1,
   output logic                       transistor_output_2,
   output logic                       transistor_output_3,
   output logic                       transistor_output_4,
   output logic                       transistor_output_5,
   output logic                       relay_contact_a,
   output logic                       relay_contact_b,
   output logic                       irq
);
   // ****************************************
   // Declarations
   // ****************************************
   logic [31:0]             func_a;
   logic [31:0]             func_b;
   logic [31:0]             sense;
   logic [15:0]             zero_speed_threshold;
   logic                    sensor_vector;
   logic [3:0]              irq_status;
   logic [3:0]              irq_mask;
   logic                    aw_held;
   logic                    w_held;
   logic [7:0]              aw_addr;
   logic [31:0]             w_data;
   logic [3:0]              w_strb;
   logic                    wr_fire;
   logic                    wr_hit;
   logic [31:0]             next_rdata;
   logic                    rd_hit;
   logic                    trip_reset_req;
   logic                    zero_speed_flag;
   logic                    operation_ready_flag;
   logic                    forward_run_flag;
   logic                    reverse_run_flag;
   logic                    alarm_flag;
   dso_pkg::dso_run_state_t run_state;
   dso_pkg::dso_run_state_t next_run_state;
   dso_pkg::dso_freq_t      cmp_freq;
   dso_pkg::dso_flags_t     flags;
   logic [3:0]              events;
   logic                    run_rejected;
   logic [5:0]              term;
   logic [15:0]             thr_merged;
   logic [15:0]             next_threshold;
   logic [47:0]             func_all;

   // ****************************************
   // Register bus helpers
   // ****************************************
   // Mapped offsets; shared by write and read decode
   function automatic logic mapped(input logic [7:0] a);
      case (a)
         `DSO_OFS_FUNC_A, `DSO_OFS_FUNC_B, `DSO_OFS_SENSE,
         `DSO_OFS_ZS_THRESH, `DSO_OFS_CONTROL, `DSO_OFS_STATUS,
         `DSO_OFS_IRQ_STATUS, `DSO_OFS_IRQ_MASK: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   endfunction

   // Byte-lane merge of write data into old value
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  st);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            merge[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
   endfunction

   // Each channel ready while nothing is parked on it
   assign s_axi_awready = !aw_held;
   assign s_axi_wready  = !w_held;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_fire = aw_held && w_held && !s_axi_bvalid;
   assign wr_hit  = wr_fire && mapped(aw_addr);

   // Address and data taken in either order
   always_ff @(posedge mclk) begin
      if (reset) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 8'h00;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held <= 1'b0;
         end
      end
   end

   // Write response; unmapped offsets answer SLVERR
   always_ff @(posedge mclk) begin
      if (reset) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `DSO_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= mapped(aw_addr) ? `DSO_RESP_OKAY : `DSO_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ****************************************
   // Configuration registers
   // ****************************************
   // Threshold clamped so it never exceeds 99.99 Hz
   always_comb begin
      thr_merged     = 16'(merge({16'h0000, zero_speed_threshold}, w_data, w_strb));
      next_threshold = (thr_merged > `DSO_ZS_THRESH_MAX) ? `DSO_ZS_THRESH_MAX : thr_merged;
   end

   // Selectors and sense settings
   always_ff @(posedge mclk) begin
      if (reset) begin
         func_a               <= `DSO_RST_FUNC_A;
         func_b               <= `DSO_RST_FUNC_B;
         sense                <= `DSO_RST_SENSE;
         zero_speed_threshold <= `DSO_RST_ZS_THRESH;
         sensor_vector        <= 1'b0;
         irq_mask             <= 4'h0;
      end else if (wr_hit) begin
         case (aw_addr)
            `DSO_OFS_FUNC_A:    func_a <= merge(func_a, w_data, w_strb);
            `DSO_OFS_FUNC_B:    func_b <= merge(func_b, w_data, w_strb) & 32'h0000_ffff;
            `DSO_OFS_SENSE:     sense <= merge(sense, w_data, w_strb) & 32'h0000_0fff;
            `DSO_OFS_ZS_THRESH: zero_speed_threshold <= next_threshold;
            `DSO_OFS_CONTROL: begin
               if (w_strb[0]) begin
                  sensor_vector <= w_data[`DSO_CTL_SENSOR_BIT];
               end
            end
            `DSO_OFS_IRQ_MASK: begin
               if (w_strb[0]) begin
                  irq_mask <= w_data[3:0];
               end
            end
            default: ;
         endcase
      end
   end

   // Trip reset from terminal or a one written to control register bit 1
   assign trip_reset_req = trip_reset ||
      (wr_hit && aw_addr == `DSO_OFS_CONTROL && w_strb[0] && w_data[`DSO_CTL_TRIPRST_BIT]);

   // ****************************************
   // Read path
   // ****************************************
   always_comb begin
      rd_hit = mapped(s_axi_araddr);
      case (s_axi_araddr)
         `DSO_OFS_FUNC_A:     next_rdata = func_a;
         `DSO_OFS_FUNC_B:     next_rdata = func_b;
         `DSO_OFS_SENSE:      next_rdata = sense;
         `DSO_OFS_ZS_THRESH:  next_rdata = {16'h0000, zero_speed_threshold};
         `DSO_OFS_CONTROL:    next_rdata = {31'h0000_0000, sensor_vector};
         `DSO_OFS_STATUS:     next_rdata = {13'h0000, run_state, 3'h0, relay_contact_a,
                                            term[4:0], 2'h0, flags};
         `DSO_OFS_IRQ_STATUS: next_rdata = {28'h000_0000, irq_status};
         `DSO_OFS_IRQ_MASK:   next_rdata = {28'h000_0000, irq_mask};
         default:             next_rdata = 32'h0000_0000;
      endcase
   end

   // Read answer one cycle after the address is taken
   always_ff @(posedge mclk) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `DSO_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= rd_hit ? `DSO_RESP_OKAY : `DSO_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************
   // Status flags
   // ****************************************
   // Encoder feedback compares the real rotor speed
   assign cmp_freq = sensor_vector ? motor_freq : output_freq;

   // Zero-speed detect; a zero threshold never fires
   always_ff @(posedge mclk) begin
      if (reset) begin
         zero_speed_flag <= 1'b0;
      end else begin
         zero_speed_flag <= cmp_freq < zero_speed_threshold;
      end
   end

   // Trip latch; a trip beats a reset in the same cycle
   always_ff @(posedge mclk) begin
      if (reset) begin
         alarm_flag <= 1'b0;
      end else if (trip_event) begin
         alarm_flag <= 1'b1;
      end else if (trip_reset_req) begin
         alarm_flag <= 1'b0;
      end
   end

   // Ready only with good supply and no pending trip
   always_ff @(posedge mclk) begin
      if (reset) begin
         operation_ready_flag <= 1'b0;
      end else begin
         operation_ready_flag <= supply_ok && !trip_event &&
                                 !(alarm_flag && !trip_reset_req);
      end
   end

   // Run sequencing; a run lasts until command off and output at 0 Hz, or until a trip
   always_comb begin
      next_run_state = run_state;
      run_rejected   = 1'b0;
      case (run_state)
         dso_pkg::DSO_ST_STOP: begin
            if (run_fwd_cmd ^ run_rev_cmd) begin
               if (!operation_ready_flag) begin
                  run_rejected = 1'b1;
               end else if (run_fwd_cmd) begin
                  next_run_state = dso_pkg::DSO_ST_FWD;
               end else begin
                  next_run_state = dso_pkg::DSO_ST_REV;
               end
            end
         end
         dso_pkg::DSO_ST_FWD: begin
            if (!run_fwd_cmd && output_freq == 16'h0000) begin
               next_run_state = dso_pkg::DSO_ST_STOP;
            end
         end
         dso_pkg::DSO_ST_REV: begin
            if (!run_rev_cmd && output_freq == 16'h0000) begin
               next_run_state = dso_pkg::DSO_ST_STOP;
            end
         end
         default: next_run_state = dso_pkg::DSO_ST_STOP;
      endcase
      // Trip shuts the output off at once
      if (trip_event || alarm_flag) begin
         next_run_state = dso_pkg::DSO_ST_STOP;
      end
   end

   // Direction flags follow the run state
   always_ff @(posedge mclk) begin
      if (reset) begin
         run_state        <= dso_pkg::DSO_ST_STOP;
         forward_run_flag <= 1'b0;
         reverse_run_flag <= 1'b0;
         drive_active     <= 1'b0;
      end else begin
         run_state        <= next_run_state;
         forward_run_flag <= next_run_state == dso_pkg::DSO_ST_FWD;
         reverse_run_flag <= next_run_state == dso_pkg::DSO_ST_REV;
         drive_active     <= next_run_state != dso_pkg::DSO_ST_STOP;
      end
   end

   assign flags = {alarm_flag, reverse_run_flag, forward_run_flag,
                   operation_ready_flag, zero_speed_flag};

   // ****************************************
   // Interrupts
   // ****************************************
   assign events = {run_rejected, trip_event,
                    cmp_freq < zero_speed_threshold && !zero_speed_flag,
                    supply_ok && !operation_ready_flag && !alarm_flag};

   // Sticky events; a new event wins over write-one-to-clear
   always_ff @(posedge mclk) begin
      if (reset) begin
         irq_status <= 4'h0;
      end else if (wr_hit && aw_addr == `DSO_OFS_IRQ_STATUS && w_strb[0]) begin
         irq_status <= (irq_status & ~w_data[3:0]) | events;
      end else begin
         irq_status <= irq_status | events;
      end
   end

   assign irq = |(irq_status & irq_mask);

   // ****************************************
   // Output terminals
   // ****************************************
   // Selectors packed flat so every slice stays in range; relay byte lands at index 5
   assign func_all = {func_b[15:0], func_a};

   // Five transistor outputs plus the relay, identical cells
   generate
      for (genvar g = 0; g < 6; g++) begin : g_term
         dso_out_cell u_cell (
            .mclk      (mclk),
            .reset     (reset),
            .func_sel  (func_all[g*8 +: 8]),
            .sense_sel (sense[g*2 +: 2]),
            .flags     (flags),
            .drive     (term[g])
         );
      end
   endgenerate

   assign transistor_output_1 = term[0];
   assign transistor_output_2 = term[1];
   assign transistor_output_3 = term[2];
   assign transistor_output_4 = term[3];
   assign transistor_output_5 = term[4];
   // Relay a-contact closes when the cell drives; b is the opposite pair
   assign relay_contact_a = term[5];
   assign relay_contact_b = !term[5];

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   property p_relay_default;
      @(posedge mclk) disable iff (1'b0)
      reset |=> func_b[`DSO_FN_RELAY_LSB +: 8] == `DSO_FN_ALARM;
   endproperty
   a_relay_default: assert property (p_relay_default)
      else $error("relay selector not alarm after reset");

   property p_relay_nc;
      (sense[`DSO_SENSE_RELAY_LSB +: 2] == `DSO_SENSE_NC &&
       func_b[`DSO_FN_RELAY_LSB +: 8] == `DSO_FN_ALARM && alarm_flag)[*2]
         |-> !relay_contact_a && relay_contact_b;
   endproperty
   a_relay_nc: assert property (p_relay_nc)
      else $error("relay a-contact closed during alarm");

   property p_zero_speed;
      ##1 zero_speed_flag == ($past(cmp_freq) < $past(zero_speed_threshold));
   endproperty
   a_zero_speed: assert property (p_zero_speed)
      else $error("zero-speed flag wrong");

   property p_sensor_pick;
      sensor_vector |-> cmp_freq == motor_freq;
   endproperty
   a_sensor_pick: assert property (p_sensor_pick)
      else $error("zero-speed not on motor frequency");

   property p_ready_trip;
      alarm_flag && !trip_reset_req |=> !operation_ready_flag;
   endproperty
   a_ready_trip: assert property (p_ready_trip)
      else $error("ready during trip");

   property p_run_ignored;
      run_state == dso_pkg::DSO_ST_STOP && !operation_ready_flag
         |=> run_state == dso_pkg::DSO_ST_STOP;
   endproperty
   a_run_ignored: assert property (p_run_ignored)
      else $error("run accepted while not ready");

   property p_fwd_flag;
      forward_run_flag |-> run_state == dso_pkg::DSO_ST_FWD && !reverse_run_flag;
   endproperty
   a_fwd_flag: assert property (p_fwd_flag)
      else $error("forward flag outside forward run");

   property p_rev_flag;
      reverse_run_flag |-> run_state == dso_pkg::DSO_ST_REV;
   endproperty
   a_rev_flag: assert property (p_rev_flag)
      else $error("reverse flag outside reverse run");

   property p_alarm_hold;
      trip_event |=> alarm_flag && !drive_active ##1
         (alarm_flag || $past(trip_reset_req));
   endproperty
   a_alarm_hold: assert property (p_alarm_hold)
      else $error("alarm or shutdown missing after trip");
endmodule

// ==== verif/dso_seq_ctl.sv ====
`timescale 1ns/1ps
// ****************************************
// Far-side sequence controller
// ****************************************
module dso_seq_ctl (
   input  wire logic mclk,
   input  wire logic reset,
   input  wire logic want_fwd,
   input  wire logic want_rev,
   output logic      run_fwd_cmd,
   output logic      run_rev_cmd
);
   // Level run commands, relayed a cycle late as a PLC scan would
   always_ff @(posedge mclk) begin
      if (reset) begin
         run_fwd_cmd <= 1'b0;
         run_rev_cmd <= 1'b0;
      end else begin
         run_fwd_cmd <= want_fwd;
         run_rev_cmd <= want_rev;
      end
   end
endmodule

// ==== verif/dso_status_outputs_bench.sv ====
`timescale 1ns/1ps
`include "dso_map.svh"
module dso_status_outputs_bench;
   logic               mclk, reset, awv, wv, br, arv, rr, awr, wrd, bv, arr, rv;
   logic               sok, trip, trst, wf, wr, fc, rc, act, ca, cb, irq;
   logic [7:0]         aw, ar;
   logic [31:0]        wd, rd, v;
   logic [1:0]         bres, rres, rsp;
   logic [4:0]         t;
   dso_pkg::dso_freq_t ofreq, mfreq;
   int                 err_count = 0;
   int                 n_compared = 0;
   dso_status_outputs DUT (.mclk(mclk), .reset(reset), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_awaddr(aw), .s_axi_wvalid(wv), .s_axi_wready(wrd),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_bresp(bres), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ar),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd), .s_axi_rresp(rres),
      .output_freq(ofreq), .motor_freq(mfreq), .supply_ok(sok), .trip_event(trip),
      .trip_reset(trst), .run_fwd_cmd(fc), .run_rev_cmd(rc), .drive_active(act),
      .transistor_output_1(t[0]), .transistor_output_2(t[1]), .transistor_output_3(t[2]),
      .transistor_output_4(t[3]), .transistor_output_5(t[4]), .relay_contact_a(ca),
      .relay_contact_b(cb), .irq(irq));
   dso_seq_ctl ctl (.mclk(mclk), .reset(reset), .want_fwd(wf), .want_rev(wr),
      .run_fwd_cmd(fc), .run_rev_cmd(rc));
   // ****************************************
   // Bus and check helpers
   // ****************************************
   task end_of_test;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Sampling right after the edge sees last cycle's settled values
   task cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      int n;
      awv <= 1'b1;
      aw <= a;
      wv <= 1'b1;
      wd <= d;
      br <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
         n++;
      end while (!bv && n < 64);
      rsp = bres;
      br <= 1'b0;
      if (n >= 64) begin
         err_count++;
         end_of_test();
      end
   endtask
   task rd_reg(input logic [7:0] a);
      int n;
      arv <= 1'b1;
      ar <= a;
      rr <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         if (arr) arv <= 1'b0;
         n++;
      end while (!rv && n < 64);
      v = rd;
      rsp = rres;
      rr <= 1'b0;
      if (n >= 64) begin
         err_count++;
         end_of_test();
      end
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task t_reset;
      rd_reg(`DSO_OFS_FUNC_B);
      chk("func_b", v, `DSO_RST_FUNC_B);
      rd_reg(`DSO_OFS_SENSE);
      chk("sense", v, `DSO_RST_SENSE);
      chk("contact_a", ca, 1'b1);
      chk("contact_b", cb, 1'b0);
      rd_reg(8'h40);
      chk("unmapped", rsp, `DSO_RESP_SLVERR);
      wr_reg(8'h40, 32'h0000_0001);
      chk("wr_unmapped", rsp, `DSO_RESP_SLVERR);
      rd_reg(`DSO_OFS_ZS_THRESH);
      chk("thr_dflt", v, 32'h0000_0000);
      rd_reg(`DSO_OFS_STATUS);
      chk("zs_dflt", v[0], 1'b0);
      chk("ready_dflt", v[1], 1'b1);
   endtask
   task t_flags;
      wr_reg(`DSO_OFS_FUNC_A, 32'h3433_3215);
      chk("wr_okay", rsp, `DSO_RESP_OKAY);
      wr_reg(`DSO_OFS_ZS_THRESH, 32'h0000_0064);
      ofreq <= 16'h0032;
      cyc(6);
      chk("zs_below", t[0], 1'b1);
      chk("ready", t[1], 1'b1);
      chk("fwd_stop", t[2], 1'b0);
      chk("rev_stop", t[3], 1'b0);
      ofreq <= 16'h0064;
      cyc(6);
      chk("zs_at", t[0], 1'b0);
      wf <= 1'b1;
      cyc(6);
      chk("fwd_run", t[2], 1'b1);
      chk("rev_in_fwd", t[3], 1'b0);
      wf <= 1'b0;
      ofreq <= 16'h0000;
      cyc(6);
      chk("fwd_off", t[2], 1'b0);
      wr <= 1'b1;
      cyc(6);
      chk("rev_run", t[3], 1'b1);
      chk("fwd_in_rev", t[2], 1'b0);
      wr <= 1'b0;
      // Encoder mode must ignore the commanded frequency, now zero
      wr_reg(`DSO_OFS_CONTROL, 32'h0000_0001);
      mfreq <= 16'h0200;
      cyc(6);
      chk("zs_motor", t[0], 1'b0);
      mfreq <= 16'h0000;
      wr_reg(`DSO_OFS_CONTROL, 32'h0000_0000);
      wr_reg(`DSO_OFS_ZS_THRESH, 32'h0000_ffff);
      rd_reg(`DSO_OFS_ZS_THRESH);
      chk("zs_clamp", v, 32'h0000_270f);
   endtask
   task t_sense;
      wr_reg(`DSO_OFS_SENSE, 32'h0000_0401);
      cyc(4);
      chk("p1_nc", t[0], 1'b0);
      wr_reg(`DSO_OFS_SENSE, 32'h0000_0000);
      cyc(4);
      chk("p1_no", t[0], 1'b1);
      chk("relay00_a", ca, 1'b0);
      chk("relay00_b", cb, 1'b1);
      wr_reg(`DSO_OFS_SENSE, `DSO_RST_SENSE);
   endtask
   task t_trip;
      wr_reg(`DSO_OFS_FUNC_B, 32'h0000_0505);
      wr_reg(`DSO_OFS_IRQ_MASK, 32'h0000_0004);
      trip <= 1'b1;
      cyc(1);
      trip <= 1'b0;
      cyc(8);
      chk("trip_a", ca, 1'b0);
      chk("trip_p5", t[4], 1'b1);
      chk("trip_stop", act, 1'b0);
      chk("irq_on", irq, 1'b1);
      wr_reg(`DSO_OFS_IRQ_STATUS, 32'h0000_0004);
      cyc(2);
      chk("irq_off", irq, 1'b0);
      wr_reg(`DSO_OFS_CONTROL, 32'h0000_0002);
      cyc(6);
      chk("rst_a", ca, 1'b1);
      chk("rst_p5", t[4], 1'b0);
      // Trip and terminal reset together: the trip must win
      trip <= 1'b1;
      trst <= 1'b1;
      cyc(1);
      trip <= 1'b0;
      trst <= 1'b0;
      cyc(4);
      chk("trip_wins", ca, 1'b0);
      trst <= 1'b1;
      cyc(1);
      trst <= 1'b0;
      cyc(4);
      chk("trst_a", ca, 1'b1);
   endtask
   task t_notready;
      sok <= 1'b0;
      cyc(6);
      chk("not_ready", t[1], 1'b0);
      wf <= 1'b1;
      cyc(6);
      chk("run_ignored", act, 1'b0);
      rd_reg(`DSO_OFS_IRQ_STATUS);
      chk("rejected", v[3], 1'b1);
      wf <= 1'b0;
      sok <= 1'b1;
      cyc(6);
   endtask
   // Clock and main sequence
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   initial begin
      {reset, sok} = 2'b11;
      {awv, wv, br, arv, rr, trip, trst, wf, wr} = 9'h000;
      {aw, ar, wd, ofreq, mfreq} = 80'h0;
      cyc(6);
      reset <= 1'b0;
      cyc(2);
      t_reset();
      t_flags();
      t_sense();
      t_trip();
      t_notready();
      end_of_test();
   end
endmodule
